//--- core/cic_pkg.sv
// package: constants, register map and types of the counter input group
package cic_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned MS_NS           = 1000000;
  localparam int unsigned MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CHAT_UNIT_MS    = 100;
  localparam int unsigned MIN_TO_MS       = 60000;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_GROUP_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CH_CFG0      = 8'h04;
  localparam logic [7:0] OFF_STATUS       = 8'h14;
  localparam logic [7:0] OFF_COUNT0       = 8'h18;
  localparam logic [7:0] OFF_COUNT_CLEAR  = 8'h28;
  localparam logic [7:0] OFF_TZ           = 8'h2C;
  localparam logic [7:0] OFF_UTC_LO       = 8'h30;
  localparam logic [7:0] OFF_UTC_HI       = 8'h34;

  // ==========================================================
  // group control fields
  localparam int unsigned GC_FUNC_LSB     = 0;
  localparam int unsigned GC_DEB_TYPE     = 2;
  localparam int unsigned GC_DECHAT       = 3;
  localparam int unsigned GC_TS_MODE      = 4;
  localparam int unsigned GC_CUSTOM_TZ    = 5;
  localparam logic [31:0] GC_RESET        = 32'h0000_0001;

  // channel config fields
  localparam int unsigned CC_DISABLE      = 0;
  localparam int unsigned CC_EDGE_LSB     = 1;
  localparam int unsigned CC_DEB_LSB      = 8;
  localparam int unsigned CC_CCNT_LSB     = 16;
  localparam int unsigned CC_CTIME_LSB    = 24;
  localparam logic [31:0] CC_RESET        = 32'h0101_0100;

  // status fields
  localparam int unsigned ST_CHAT_ACTIVE  = 15;

  // time zone fields: custom minutes low half, listed zone quarters high
  localparam int unsigned TZ_LIST_LSB     = 16;
  localparam int unsigned TZ_QUARTER_MIN  = 15;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    CIC_FUNC_DISCRETE = 2'b00,
    CIC_FUNC_COUNTER  = 2'b01,
    CIC_FUNC_TSTAMP   = 2'b10
  } cic_func_t;

  typedef enum logic [1:0] {
    CIC_EDGE_BOTH    = 2'b00,
    CIC_EDGE_RISE    = 2'b01,
    CIC_EDGE_FALL    = 2'b10
  } cic_edge_t;

  typedef enum logic {
    CIC_DEB_STEADY   = 1'b0,
    CIC_DEB_INTEG    = 1'b1
  } cic_deb_t;

  typedef enum logic {
    CIC_TS_APPLICATIVE = 1'b0,
    CIC_TS_SYSTEM      = 1'b1
  } cic_ts_mode_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] chat_time;
    logic [7:0] chat_count;
    logic [7:0] deb_time;
    logic [1:0] edge_sel;
    logic       disable_ch;
  } cic_ch_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] local_ms;
    logic [7:0]  dst_min;
  } cic_time_in_t;

endpackage

//--- core/cic_channel.sv
// module: debounce, dechatter and edge counter for one input channel
`timescale 1ns/1ps

module cic_channel (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 din,
  input  wire logic                 ms_tick,
  input  wire logic                 unit_tick,
  input  wire logic                 deb_type,
  input  wire logic                 dechat_en,
  input  wire logic                 count_en,
  input  wire logic                 clear,
  input  wire cic_pkg::cic_ch_cfg_t cfg,
  output logic                      value,
  output logic [31:0]               count,
  output logic                      chat_active
);

  logic       last_in;
  logic [8:0] deb_timer;
  logic [7:0] integ;
  logic       filt;
  logic       filt_d;
  logic [8:0] chat_timer;
  logic [8:0] chat_edges;
  logic       win_open;
  logic       raw_edge;
  logic       edge_ok;
  logic       pass_edge;

  // ==========================================================
  // debounce
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_in   <= 1'b0;
      deb_timer <= 9'h000;
      integ     <= 8'h00;
      filt      <= 1'b0;
    end else if (cfg.disable_ch) begin
      last_in   <= din;
      deb_timer <= 9'h000;
      integ     <= 8'h00;
      filt      <= 1'b0;
    end else begin
      last_in <= din;
      if (cfg.deb_time == 8'h00) begin
        filt  <= din;
        integ <= 8'h00;
      end else if (deb_type == cic_pkg::CIC_DEB_STEADY) begin
        if (din != last_in || din == filt) begin
          deb_timer <= 9'h000;
        end else if (ms_tick) begin
          if (deb_timer > {1'b0, cfg.deb_time}) begin
            filt      <= din;
            deb_timer <= 9'h000;
          end else begin
            deb_timer <= deb_timer + 9'h001;
          end
        end
      end else if (ms_tick) begin
        if (din && integ < cfg.deb_time) begin
          integ <= integ + 8'h01;
        end else if (!din && integ != 8'h00) begin
          integ <= integ - 8'h01;
        end
        if (din && integ + 8'h01 >= cfg.deb_time) begin
          filt <= 1'b1;
        end else if (!din && integ <= 8'h01) begin
          filt <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // edge selection
  always_comb begin
    raw_edge = filt != filt_d;
    case (cic_pkg::cic_edge_t'(cfg.edge_sel))
      cic_pkg::CIC_EDGE_RISE: edge_ok = filt & ~filt_d;
      cic_pkg::CIC_EDGE_FALL: edge_ok = ~filt & filt_d;
      default:                edge_ok = raw_edge;
    endcase
    pass_edge = edge_ok && (!dechat_en || !chat_active);
  end

  // ==========================================================
  // dechatter window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_d      <= 1'b0;
      chat_timer  <= 9'h000;
      chat_edges  <= 9'h000;
      win_open    <= 1'b0;
      chat_active <= 1'b0;
    end else begin
      filt_d <= filt;
      if (!dechat_en || cfg.disable_ch) begin
        win_open    <= 1'b0;
        chat_active <= 1'b0;
        chat_edges  <= 9'h000;
        chat_timer  <= 9'h000;
      end else if (!win_open) begin
        if (raw_edge) begin
          win_open   <= 1'b1;
          chat_edges <= 9'h001;
          chat_timer <= 9'h000;
        end
      end else begin
        if (raw_edge && chat_edges != 9'h1FF) begin
          chat_edges <= chat_edges + 9'h001;
        end
        if (raw_edge && chat_edges >= {1'b0, cfg.chat_count}) begin
          chat_active <= 1'b1;
        end
        if (unit_tick) begin
          if (chat_timer + 9'h001 >= {1'b0, cfg.chat_time}) begin
            win_open    <= 1'b0;
            chat_active <= 1'b0;
          end else begin
            chat_timer <= chat_timer + 9'h001;
          end
        end
      end
    end
  end

  // ==========================================================
  // counter and value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0000_0000;
      value <= 1'b0;
    end else begin
      value <= filt & ~cfg.disable_ch;
      if (clear) begin
        count <= 32'h0000_0000;
      end else if (count_en && !cfg.disable_ch && pass_edge) begin
        count <= count + 32'h0000_0001;
      end
    end
  end

endmodule

//--- core/cic_group.sv
// module: counter input group with apb registers and utc conversion
`timescale 1ns/1ps

// Contract
// - group function: discrete, counter, time stamping (time stamping acts as discrete, no stamps are taken)
// - steady debounce: stable longer than time
// - integrating debounce: integral reaches time
// - dechatter off: chatter settings ignored
// - dechatter on: filter every channel
// - disabled channel: no processing, value zero
// - edge option: both, rising, falling
// - debounce time 0 to 255 ms, default 1
// - debounce time zero passes directly
// - chatter count 1 to 255, default 1
// - chatter window 1 to 255 x 100 ms
// - local time converted to utc milliseconds
// - daylight saving taken only from receiver
// - custom zone uses offset in minutes
// - time stamping mode, applicative default (mode bit is only stored and read back, it changes nothing)
// - readable count and clear command
// - chatter active status shared by group
module cic_group #(
  parameter int unsigned N_CH      = 4,
  parameter int unsigned MS_CYCLES = cic_pkg::MS_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [N_CH-1:0]      field_in,
  input  wire cic_pkg::cic_time_in_t time_in,
  output logic [N_CH-1:0]           chan_value,
  output logic                      chatter_suppress_active,
  output logic [63:0]               utc_ms,
  output logic                      utc_valid
);

  logic [31:0]       group_ctrl;
  logic [31:0]       ch_cfg [N_CH];
  logic [31:0]       tz_reg;
  logic [N_CH-1:0]   sync1;
  logic [N_CH-1:0]   sync2;
  logic [15:0]       ms_cnt;
  logic              ms_tick;
  logic [6:0]        unit_cnt;
  logic              unit_tick;
  logic [N_CH-1:0]   count_clear_cmd;
  logic [N_CH-1:0]   ch_value;
  logic [N_CH-1:0]   ch_chat;
  logic [31:0]       count_value [N_CH];
  logic [31:0]       next_rdata;
  logic              next_err;
  logic              wr_en;
  logic              setup;
  logic [1:0]        func;
  logic signed [31:0] offset_min;

  assign func  = group_ctrl[cic_pkg::GC_FUNC_LSB +: 2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int unsigned n);
    in_range = a >= base && a < base + 8'(4 * n) && a[1:0] == 2'b00;
  endfunction

  function automatic int unsigned word_idx(input logic [7:0] a,
                                           input logic [7:0] base);
    word_idx = 32'(8'(a - base) >> 2);
  endfunction

  // ==========================================================
  // input synchronisers and time bases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= field_in;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt    <= 16'h0000;
      ms_tick   <= 1'b0;
      unit_cnt  <= 7'h00;
      unit_tick <= 1'b0;
    end else begin
      ms_tick   <= 1'b0;
      unit_tick <= 1'b0;
      if (ms_cnt >= 16'(MS_CYCLES - 1)) begin
        ms_cnt  <= 16'h0000;
        ms_tick <= 1'b1;
        if (unit_cnt >= 7'(cic_pkg::CHAT_UNIT_MS - 1)) begin
          unit_cnt  <= 7'h00;
          unit_tick <= 1'b1;
        end else begin
          unit_cnt <= unit_cnt + 7'h01;
        end
      end else begin
        ms_cnt <= ms_cnt + 16'h0001;
      end
    end
  end

  // ==========================================================
  // channels
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    cic_pkg::cic_ch_cfg_t cfg_i;
    // unpack the register word field by field, not by a raw bit cast
    assign cfg_i = '{
      chat_time:  ch_cfg[i][cic_pkg::CC_CTIME_LSB +: 8],
      chat_count: ch_cfg[i][cic_pkg::CC_CCNT_LSB +: 8],
      deb_time:   ch_cfg[i][cic_pkg::CC_DEB_LSB +: 8],
      edge_sel:   ch_cfg[i][cic_pkg::CC_EDGE_LSB +: 2],
      disable_ch: ch_cfg[i][cic_pkg::CC_DISABLE]
    };
    cic_channel u_ch (
      .pclk        (pclk),
      .presetn     (presetn),
      .din         (sync2[i]),
      .ms_tick     (ms_tick),
      .unit_tick   (unit_tick),
      .deb_type    (group_ctrl[cic_pkg::GC_DEB_TYPE]),
      .dechat_en   (group_ctrl[cic_pkg::GC_DECHAT]),
      .count_en    (func == cic_pkg::CIC_FUNC_COUNTER),
      .clear       (count_clear_cmd[i]),
      .cfg         (cfg_i),
      .value       (ch_value[i]),
      .count       (count_value[i]),
      .chat_active (ch_chat[i])
    );
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_value              <= '0;
      chatter_suppress_active <= 1'b0;
    end else begin
      chan_value              <= ch_value;
      chatter_suppress_active <= |ch_chat;
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_ctrl <= cic_pkg::GC_RESET;
      tz_reg     <= 32'h0000_0000;
      for (int i = 0; i < N_CH; i++) begin
        ch_cfg[i] <= cic_pkg::CC_RESET;
      end
    end else if (wr_en) begin
      if (paddr == cic_pkg::OFF_GROUP_CTRL) begin
        group_ctrl <= pwdata & 32'h0000_003F;
      end else if (in_range(paddr, cic_pkg::OFF_CH_CFG0, N_CH)) begin
        ch_cfg[word_idx(paddr, cic_pkg::OFF_CH_CFG0)] <=
          pwdata & 32'hFFFF_FF07;
      end else if (paddr == cic_pkg::OFF_TZ) begin
        tz_reg <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_clear_cmd <= '0;
    end else if (wr_en && paddr == cic_pkg::OFF_COUNT_CLEAR) begin
      count_clear_cmd <= pwdata[N_CH-1:0];
    end else begin
      count_clear_cmd <= '0;
    end
  end

  // ==========================================================
  // register reads, answered one cycle after setup
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr == cic_pkg::OFF_GROUP_CTRL) begin
      next_rdata = group_ctrl;
    end else if (in_range(paddr, cic_pkg::OFF_CH_CFG0, N_CH)) begin
      next_rdata = ch_cfg[word_idx(paddr, cic_pkg::OFF_CH_CFG0)];
    end else if (paddr == cic_pkg::OFF_STATUS) begin
      next_rdata[N_CH-1:0] = chan_value;
      next_rdata[cic_pkg::ST_CHAT_ACTIVE] = chatter_suppress_active;
    end else if (in_range(paddr, cic_pkg::OFF_COUNT0, N_CH)) begin
      next_rdata = count_value[word_idx(paddr, cic_pkg::OFF_COUNT0)];
    end else if (paddr == cic_pkg::OFF_COUNT_CLEAR) begin
      next_rdata = 32'h0000_0000;
    end else if (paddr == cic_pkg::OFF_TZ) begin
      next_rdata = tz_reg;
    end else if (paddr == cic_pkg::OFF_UTC_LO) begin
      next_rdata = utc_ms[31:0];
    end else if (paddr == cic_pkg::OFF_UTC_HI) begin
      next_rdata = utc_ms[63:32];
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & next_err;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // ==========================================================
  // local time to utc milliseconds
  always_comb begin
    if (group_ctrl[cic_pkg::GC_CUSTOM_TZ]) begin
      offset_min = 32'(signed'(tz_reg[15:0]));
    end else begin
      offset_min = 32'(signed'(tz_reg[cic_pkg::TZ_LIST_LSB +: 8]))
                   * 32'(cic_pkg::TZ_QUARTER_MIN);
    end
    offset_min = offset_min + 32'(time_in.dst_min);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      utc_ms    <= 64'h0000_0000_0000_0000;
      utc_valid <= 1'b0;
    end else begin
      utc_valid <= time_in.valid;
      if (time_in.valid) begin
        // sign-extend the offset before the product so west zones work
        utc_ms <= time_in.local_ms
                  - 64'(offset_min)
                    * 64'(signed'(cic_pkg::MIN_TO_MS));
      end
    end
  end

endmodule

//--- bench/cic_group_assertions.sv
// checker: port-level assertions for the counter input group
`timescale 1ns/1ps

module cic_group_chk #(
  parameter int unsigned N_CH      = 4,
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [N_CH-1:0]       field_in,
  input wire cic_pkg::cic_time_in_t time_in,
  input wire logic [N_CH-1:0]       chan_value,
  input wire logic                  chatter_suppress_active,
  input wire logic [63:0]           utc_ms,
  input wire logic                  utc_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // bus
  sequence apb_setup;
    psel && !penable;
  endsequence
  chk_ready_after_setup: assert property (apb_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read not zero");
  // ==========================================================
  // time and channels
  chk_utc_follows: assert property (time_in.valid |=> utc_valid)
    else $error("utc_valid missing");
  chk_utc_cause: assert property (
    utc_valid |-> $past(time_in.valid))
    else $error("utc_valid without time word");
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    // pin to chan_value: two sync flops, filter, value, output flop
    chk_value_rise: assert property (
      $rose(chan_value[i]) |-> $past(field_in[i], 5))
      else $error("value rose without input");
  end
  cover property (chatter_suppress_active);
endmodule

bind cic_group cic_group_chk #(.N_CH(N_CH), .MS_CYCLES(MS_CYCLES)) chk_u (.*);

//--- bench/cic_field_model.sv
// partner: field inputs and external time receiver
`timescale 1ns/1ps

module cic_field_model (
  input  wire logic                 pclk,
  input  wire logic [3:0]           lvl,
  input  wire logic                 send,
  input  wire logic [63:0]          local_ms,
  input  wire logic [7:0]           dst_min,
  output logic [3:0]                field_in,
  output cic_pkg::cic_time_in_t     time_in
);
  initial field_in = 4'h0;
  initial time_in = '0;
  always @(posedge pclk) field_in <= lvl;
  // receiver word carries its own dst offset; idle word is scrambled
  always @(posedge pclk) begin
    time_in.valid    <= send;
    time_in.local_ms <= send ? local_ms : ~time_in.local_ms;
    time_in.dst_min  <= send ? dst_min : ~time_in.dst_min;
  end
endmodule

//--- bench/cic_group_tb.sv
// testbench: counter input group over apb
`timescale 1ns/1ps

module cic_group_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, send = 0;
  logic [7:0] paddr = 8'h00, dst = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, csa, utc_valid;
  logic [3:0] lvl = 4'h0, field_in, chan_value;
  logic [63:0] utc_ms, lms = 64'h0;
  cic_pkg::cic_time_in_t time_in;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  localparam logic [63:0] X = 64'h0000_0180_0000_0000;

  always #20 pclk = ~pclk;
  cic_field_model fm_u (.pclk(pclk), .lvl(lvl), .send(send),
    .local_ms(lms), .dst_min(dst), .field_in(field_in), .time_in(time_in));
  cic_group #(.N_CH(4), .MS_CYCLES(10)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .field_in(field_in), .time_in(time_in),
    .chan_value(chan_value), .chatter_suppress_active(csa),
    .utc_ms(utc_ms), .utc_valid(utc_valid));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    cmp("rdata", {32'h0, e}, {32'h0, rd});
  endtask
  function automatic logic [31:0] cfg(logic dis, logic [1:0] ed,
      logic [7:0] deb, logic [7:0] cc, logic [7:0] ct);
    return {ct, cc, deb, 5'h00, ed, dis};
  endfunction
  task automatic hold(input logic [3:0] l, input int n);
    @(posedge pclk);
    lvl <= l;
    repeat (n) @(posedge pclk);
  endtask
  task automatic utc(input logic [7:0] dm, input logic [63:0] e);
    @(posedge pclk);
    send <= 1; lms <= X; dst <= dm;
    @(posedge pclk);
    send <= 0;
    repeat (2) @(posedge pclk);
    cmp("utc_valid", 64'h1, {63'h0, utc_valid});
    cmp("utc_ms", e, utc_ms);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rdc(cic_pkg::OFF_GROUP_CTRL, cic_pkg::GC_RESET);
    rdc(cic_pkg::OFF_CH_CFG0, cic_pkg::CC_RESET);
    rdc(8'h40, 32'h0);
    cmp("err", 64'h1, {63'h0, err});
    rdc(8'h05, 32'h0);
    cmp("err", 64'h1, {63'h0, err});
    wr(8'h04, cfg(0, 2'h0, 8'h00, 8'h01, 8'h01));
    wr(8'h08, cfg(0, 2'h0, 8'h03, 8'h01, 8'h01));
    wr(8'h0C, cfg(0, 2'h1, 8'h00, 8'h01, 8'h01));
    wr(8'h10, cfg(0, 2'h2, 8'h00, 8'h01, 8'h01));
    hold(4'hF, 20);
    cmp("chan_value", 64'hD, {60'h0, chan_value});
    hold(4'h0, 20);
    cmp("chan_value", 64'h0, {60'h0, chan_value});
    hold(4'h2, 80);
    cmp("chan_value", 64'h2, {60'h0, chan_value});
    hold(4'h0, 80);
    rdc(8'h18, 32'h2);
    rdc(8'h1C, 32'h2);
    rdc(8'h20, 32'h1);
    rdc(8'h24, 32'h1);
    xfer(0, cic_pkg::OFF_STATUS, 32'h0);
    cmp("status", 64'h0, {32'h0, rd});
    wr(cic_pkg::OFF_COUNT_CLEAR, 32'hF);
    rdc(8'h18, 32'h0);
    rdc(8'h24, 32'h0);
    wr(8'h04, cfg(1, 2'h0, 8'h00, 8'h01, 8'h01));
    hold(4'h1, 20);
    cmp("chan_value", 64'h0, {60'h0, chan_value});
    hold(4'h0, 20);
    rdc(8'h18, 32'h0);
    wr(8'h04, cfg(0, 2'h0, 8'h00, 8'h01, 8'h01));
    wr(8'h00, 32'h5);
    hold(4'h2, 15);
    cmp("chan_value", 64'h0, {60'h0, chan_value});
    hold(4'h2, 60);
    cmp("chan_value", 64'h2, {60'h0, chan_value});
    hold(4'h0, 80);
    wr(8'h00, 32'h0);
    hold(4'h1, 20);
    hold(4'h0, 20);
    rdc(8'h18, 32'h0);
    wr(8'h00, 32'h9);
    for (int i = 0; i < 4; i++) hold(i[0] ? 4'h0 : 4'h1, 10);
    cmp("chatter", 64'h1, {63'h0, csa});
    xfer(0, cic_pkg::OFF_STATUS, 32'h0);
    cmp("status", 64'h1, {63'h0, rd[cic_pkg::ST_CHAT_ACTIVE]});
    xfer(0, 8'h18, 32'h0);
    cmp("count_lt4", 64'h1, {63'h0, rd < 32'h4});
    repeat (1100) @(posedge pclk);
    cmp("chatter", 64'h0, {63'h0, csa});
    wr(8'h00, 32'h1);
    wr(cic_pkg::OFF_COUNT_CLEAR, 32'h1);
    for (int i = 0; i < 4; i++) hold(i[0] ? 4'h0 : 4'h1, 10);
    rdc(8'h18, 32'h4);
    utc(8'h00, X);
    utc(8'h3C, X - 64'd3600000);
    wr(8'h00, 32'h21);
    wr(cic_pkg::OFF_TZ, 32'h0000_003C);
    utc(8'h00, X - 64'd3600000);
    rdc(cic_pkg::OFF_UTC_HI, 32'h0000_017F);
    wr(cic_pkg::OFF_TZ, 32'h0000_FFC4);
    utc(8'h00, X + 64'd3600000);
    wr(8'h00, 32'h1);
    wr(cic_pkg::OFF_TZ, 32'h00FC_0000);
    utc(8'h3C, X);
    wr(8'h00, 32'h11);
    rdc(8'h00, 32'h11);
    final_report();
  end
endmodule
